// [rtl/eit_target_port.sv]
// Purpose: Two-wire bus target port and angle core of a rotary encoder
// Assumes: Link logic runs on link_clk_in; samples arrive on core_clk_in
// Notes: Rules carried by this port, one a line
// Overview of operation
// RQ1 - Target only, never stretches the clock
// RQ2 - Answer address 0x36, ignore all others
// RQ3 - Controller keeps clock at or below 1 MHz
// RQ4 - Data bit taken on clock rising edge
// RQ5 - Standard, fast, fast-plus with no setting
// RQ6 - Pulses under 50 ns are ignored
// RQ7 - Data open-drain, clock input only
// RQ8 - Controller makes clocks, starts and stops
// RQ9 - Angle and magnitude by vector rotation
// RQ10 - Magnitude steers automatic gain control
// RQ11 - Quadrature outputs follow computed angle
// RQ12 - Push on fast change, slow drift ignored
// RQ13 - Steps under half turn shown promptly
// RQ14 - Tracks rotation up to 456 rpm
// RQ15 - Zero and configuration written over bus
// RQ16 - Bad pointer not acknowledged, transfer continues
// RQ17 - Pointer steps after each byte, wraps
// RQ18 - High result bytes hold pointer on read
// RQ19 - Bad address reads return zero
// RQ20 - Phases a quarter apart, lead gives direction
// RQ21 - Data released on acknowledge and after stop read
`timescale 1ns/10ps
module eit_target_port
	import eit_pkg::*;
#(
	parameter int ITER_P = ITER
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out_out,
	output logic sda_oe_out,
	input wire logic [11:0] sample_x_in,
	input wire logic [11:0] sample_y_in,
	input wire logic sample_valid_in,
	output logic quad_a_out,
	output logic quad_b_out,
	output logic push_out,
	output logic [7:0] agc_gain_out,
	output logic otp_burned_out
);

	if (ITER_P < 8 || ITER_P > 12) begin : g_chk
		$error("ITER_P must lie in 8..12");
	end

	// ------------------------------------------------------------
	// Link reset and input filter
	// ------------------------------------------------------------
	logic [1:0] lrst_reg;
	logic lrst_n;
	logic [1:0] pin_w;
	logic [1:0] pin_s1_reg;
	logic [1:0] pin_s2_reg;
	logic [1:0] line_reg;
	logic [1:0] line_d_reg;
	logic [CNT_W-1:0] flt_cnt_reg [2];

	always_ff @(posedge link_clk_in) begin
		lrst_reg <= {lrst_reg[0], rst_n_in};
	end
	assign lrst_n = lrst_reg[1];
	assign pin_w = {sda_in, scl_in};

	genvar g;
	for (g = 0; g < 2; g++) begin : g_flt
		always_ff @(posedge link_clk_in) begin
			pin_s1_reg[g] <= pin_w[g];
			pin_s2_reg[g] <= pin_s1_reg[g];
		end
		// Level taken only after SPIKE_CYC+1 equal samples, same at every bus speed
		always_ff @(posedge link_clk_in) begin
			if (!lrst_n) begin
				line_reg[g] <= 1'b1;
				flt_cnt_reg[g] <= '0;
			end else if (pin_s2_reg[g] == line_reg[g]) begin
				flt_cnt_reg[g] <= '0;
			end else if (flt_cnt_reg[g] == CNT_W'(SPIKE_CYC)) begin // [RQ6] [RQ5] [RQ3]
				line_reg[g] <= pin_s2_reg[g];
				flt_cnt_reg[g] <= '0;
			end else begin
				flt_cnt_reg[g] <= flt_cnt_reg[g] + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!lrst_n) begin
			line_d_reg <= 2'h3;
		end else begin
			line_d_reg <= line_reg;
		end
	end

	spike_hold_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ6]
		$changed(line_reg[1]) |-> $past(flt_cnt_reg[1]) == CNT_W'(SPIKE_CYC))
		else $error("data line level changed before filter time");

	logic scl_f;
	logic sda_f;
	logic scl_rise_w;
	logic scl_fall_w;
	logic start_w;
	logic stop_w;
	assign scl_f = line_reg[0];
	assign sda_f = line_reg[1];
	assign scl_rise_w = scl_f && !line_d_reg[0];
	assign scl_fall_w = !scl_f && line_d_reg[0];
	// Start and stop come only from the controller
	assign start_w = scl_f && line_d_reg[0] && !sda_f && line_d_reg[1]; // [RQ8]
	assign stop_w = scl_f && line_d_reg[0] && sda_f && !line_d_reg[1]; // [RQ8]

	// ------------------------------------------------------------
	// Target state machine
	// ------------------------------------------------------------
	eit_state_t st_reg;
	eit_byte_t kind_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic [7:0] ptr_reg;
	logic rw_reg;
	logic oe_reg;
	logic [7:0] rd_data;
	logic hold_w;
	logic wr_w;
	logic [11:0] zero_reg;
	logic [7:0] conf_reg;
	logic burned_reg;
	logic cfg_tgl_reg;
	logic [11:0] l_raw_reg;
	logic [11:0] l_ang_reg;
	logic [11:0] l_mag_reg;
	logic [7:0] l_agc_reg;

	assign hold_w = (ptr_reg == REG_RAW_HI) || (ptr_reg == REG_ANG_HI) || (ptr_reg == REG_MAG_HI);
	assign wr_w = scl_fall_w && st_reg == ST_RX && bit_reg == 4'h8 && kind_reg == BY_DATA;

	always_comb begin
		case (ptr_reg)
			REG_ZERO_HI: rd_data = {4'h0, zero_reg[11:8]};
			REG_ZERO_LO: rd_data = zero_reg[7:0];
			REG_CONF: rd_data = conf_reg;
			REG_STAT: rd_data = {7'h00, burned_reg};
			REG_RAW_HI: rd_data = {4'h0, l_raw_reg[11:8]};
			REG_RAW_LO: rd_data = l_raw_reg[7:0];
			REG_ANG_HI: rd_data = {4'h0, l_ang_reg[11:8]};
			REG_ANG_LO: rd_data = l_ang_reg[7:0];
			REG_AGC: rd_data = l_agc_reg;
			REG_MAG_HI: rd_data = {4'h0, l_mag_reg[11:8]};
			REG_MAG_LO: rd_data = l_mag_reg[7:0];
			default: rd_data = 8'h00; // [RQ19]
		endcase
	end

	always_ff @(posedge link_clk_in) begin
		if (!lrst_n) begin
			st_reg <= ST_IDLE;
			kind_reg <= BY_ADDR;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (start_w) begin
			st_reg <= ST_RX;
			kind_reg <= BY_ADDR;
			bit_reg <= 4'h0;
			oe_reg <= 1'b0;
		end else if (stop_w) begin
			st_reg <= ST_IDLE;
			oe_reg <= 1'b0;
		end else if (scl_rise_w) begin
			if (st_reg == ST_RX) begin
				sh_reg <= {sh_reg[6:0], sda_f}; // [RQ4]
				bit_reg <= bit_reg + 4'h1;
			end else if (st_reg == ST_MACK && sda_f) begin
				st_reg <= ST_IDLE; // [RQ21]
			end
		end else if (scl_fall_w) begin
			case (st_reg)
				ST_RX: begin
					if (bit_reg == 4'h8) begin
						bit_reg <= 4'h0;
						st_reg <= ST_ACK;
						case (kind_reg)
							BY_ADDR: begin
								rw_reg <= sh_reg[0];
								oe_reg <= (sh_reg[7:1] == TARGET_ADDR); // [RQ2]
								if (sh_reg[7:1] != TARGET_ADDR) begin
									st_reg <= ST_IDLE; // [RQ2]
								end
							end
							BY_PTR: begin
								ptr_reg <= sh_reg;
								oe_reg <= eit_reg_ok(sh_reg); // [RQ16]
							end
							default: begin
								ptr_reg <= ptr_reg + 8'h01; // [RQ17]
								oe_reg <= eit_reg_ok(ptr_reg);
							end
						endcase
					end
				end
				ST_ACK: begin
					if (kind_reg == BY_ADDR && rw_reg) begin
						st_reg <= ST_TX;
						sh_reg <= rd_data;
						oe_reg <= !rd_data[7];
					end else begin
						// Released after acknowledge, next byte is received
						st_reg <= ST_RX; // [RQ16]
						oe_reg <= 1'b0; // [RQ21]
						kind_reg <= (kind_reg == BY_ADDR) ? BY_PTR : BY_DATA;
					end
				end
				ST_TX: begin
					if (bit_reg == 4'h7) begin
						st_reg <= ST_MACK;
						oe_reg <= 1'b0; // [RQ21]
						if (!hold_w) begin // [RQ18]
							ptr_reg <= ptr_reg + 8'h01; // [RQ17]
						end
					end else begin
						sh_reg <= {sh_reg[6:0], 1'b0};
						oe_reg <= !sh_reg[6];
						bit_reg <= bit_reg + 4'h1;
					end
				end
				ST_MACK: begin
					st_reg <= ST_TX;
					bit_reg <= 4'h0;
					sh_reg <= rd_data;
					oe_reg <= !rd_data[7];
				end
				default: begin
					st_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Only the data line is ever pulled low; clock has no output at all
	assign sda_out_out = 1'b0; // [RQ7] [RQ1]
	assign sda_oe_out = oe_reg; // [RQ7]
	assign otp_burned_out = burned_reg;

	oe_state_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ7]
		oe_reg |-> (st_reg == ST_ACK || st_reg == ST_TX))
		else $error("data line driven outside acknowledge or transmit");

	addr_miss_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ2]
		scl_fall_w && st_reg == ST_RX && bit_reg == 4'h8 && kind_reg == BY_ADDR && sh_reg[7:1] != TARGET_ADDR
		|=> st_reg == ST_IDLE && !oe_reg)
		else $error("foreign address not ignored");

	bit_capture_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ4]
		scl_rise_w && st_reg == ST_RX && !start_w && !stop_w |=> sh_reg[0] == $past(sda_f))
		else $error("data bit not taken on clock rise");

	ptr_nack_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ16]
		scl_fall_w && st_reg == ST_RX && bit_reg == 4'h8 && kind_reg == BY_PTR && !eit_reg_ok(sh_reg)
		|=> st_reg == ST_ACK && !oe_reg ##1 !oe_reg)
		else $error("invalid pointer acknowledged");

	write_inc_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ17]
		wr_w && !start_w && !stop_w |=> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("pointer not advanced after write byte");

	hold_ptr_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ18]
		scl_fall_w && st_reg == ST_TX && bit_reg == 4'h7 && hold_w |=> $stable(ptr_reg))
		else $error("pointer moved on high result byte");

	zero_read_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ19]
		scl_fall_w && st_reg == ST_MACK && !eit_reg_ok(ptr_reg) |=> sh_reg == 8'h00 && oe_reg)
		else $error("invalid address read not zero");

	sequence s_read_nack;
		scl_rise_w && st_reg == ST_MACK && sda_f && !start_w && !stop_w;
	endsequence
	nack_release_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RQ21]
		s_read_nack |=> st_reg == ST_IDLE && !oe_reg ##1 !oe_reg)
		else $error("data line not released after not-acknowledge");

	// ------------------------------------------------------------
	// Programmable words written over the bus
	// ------------------------------------------------------------
	always_ff @(posedge link_clk_in) begin
		if (!lrst_n) begin
			zero_reg <= ZERO_RST;
			conf_reg <= CONF_RST;
			burned_reg <= 1'b0;
			cfg_tgl_reg <= 1'b0;
		end else if (wr_w && !burned_reg) begin
			case (ptr_reg)
				REG_ZERO_HI: zero_reg[11:8] <= sh_reg[3:0]; // [RQ15]
				REG_ZERO_LO: zero_reg[7:0] <= sh_reg; // [RQ15]
				REG_CONF: conf_reg <= sh_reg; // [RQ15]
				REG_BURN: burned_reg <= (sh_reg == BURN_CMD); // [RQ15]
				default: ;
			endcase
			cfg_tgl_reg <= !cfg_tgl_reg;
		end
	end

	// ------------------------------------------------------------
	// Result snapshot crossing, core to link handshake
	// ------------------------------------------------------------
	logic snap_tgl_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic ack_tgl_reg;
	logic [11:0] c_raw_reg;
	logic [11:0] c_ang_reg;
	logic [11:0] c_mag_reg;
	logic [7:0] c_agc_reg;

	always_ff @(posedge link_clk_in) begin
		req_s1_reg <= snap_tgl_reg;
		req_s2_reg <= req_s1_reg;
	end

	// Fresh values land here so repeated reads see new results
	always_ff @(posedge link_clk_in) begin
		if (!lrst_n) begin
			ack_tgl_reg <= 1'b0;
			l_raw_reg <= 12'h000;
			l_ang_reg <= 12'h000;
			l_mag_reg <= 12'h000;
			l_agc_reg <= 8'h00;
		end else if (req_s2_reg != ack_tgl_reg) begin
			l_raw_reg <= c_raw_reg;
			l_ang_reg <= c_ang_reg;
			l_mag_reg <= c_mag_reg;
			l_agc_reg <= c_agc_reg;
			ack_tgl_reg <= req_s2_reg;
		end
	end

	// ------------------------------------------------------------
	// Core side: configuration crossing
	// ------------------------------------------------------------
	logic cfg_s1_reg;
	logic cfg_s2_reg;
	logic cfg_s3_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic [11:0] zero_c_reg;
	logic [7:0] conf_c_reg;

	always_ff @(posedge core_clk_in) begin
		cfg_s1_reg <= cfg_tgl_reg;
		cfg_s2_reg <= cfg_s1_reg;
		ack_s1_reg <= ack_tgl_reg;
		ack_s2_reg <= ack_s1_reg;
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cfg_s3_reg <= 1'b0;
			zero_c_reg <= ZERO_RST;
			conf_c_reg <= CONF_RST;
		end else begin
			cfg_s3_reg <= cfg_s2_reg;
			if (cfg_s2_reg != cfg_s3_reg) begin
				zero_c_reg <= zero_reg;
				conf_c_reg <= conf_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// vector_rotation_engine
	// ------------------------------------------------------------
	logic busy_reg;
	logic done_reg;
	logic [3:0] it_reg;
	logic signed [14:0] cx_reg;
	logic signed [14:0] cy_reg;
	logic [15:0] cz_reg;
	logic signed [14:0] sx_w;
	logic signed [14:0] sy_w;

	assign sx_w = {{3{sample_x_in[11]}}, sample_x_in};
	assign sy_w = {{3{sample_y_in[11]}}, sample_y_in};

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			it_reg <= 4'h0;
			cx_reg <= '0;
			cy_reg <= '0;
			cz_reg <= 16'h0000;
		end else begin
			done_reg <= busy_reg && it_reg == 4'(ITER_P - 1);
			if (!busy_reg && sample_valid_in) begin
				busy_reg <= 1'b1;
				it_reg <= 4'h0;
				// Fold left half plane onto the right half
				cx_reg <= sx_w[14] ? -sx_w : sx_w;
				cy_reg <= sx_w[14] ? -sy_w : sy_w;
				cz_reg <= sx_w[14] ? 16'h8000 : 16'h0000;
			end else if (busy_reg) begin
				if (cy_reg[14]) begin // [RQ9]
					cx_reg <= cx_reg - (cy_reg >>> it_reg);
					cy_reg <= cy_reg + (cx_reg >>> it_reg);
					cz_reg <= cz_reg - eit_atan(it_reg);
				end else begin
					cx_reg <= cx_reg + (cy_reg >>> it_reg);
					cy_reg <= cy_reg - (cx_reg >>> it_reg);
					cz_reg <= cz_reg + eit_atan(it_reg);
				end
				it_reg <= it_reg + 4'h1;
				if (it_reg == 4'(ITER_P - 1)) begin
					busy_reg <= 1'b0;
				end
			end
		end
	end

	sequence s_rot_start;
		!busy_reg && sample_valid_in;
	endsequence
	rot_len_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [RQ9]
		s_rot_start |=> busy_reg ##12 done_reg && !busy_reg)
		else $error("rotation did not finish in twelve steps");

	// ------------------------------------------------------------
	// Gain control, push detect and snapshot
	// ------------------------------------------------------------
	logic [11:0] mag_w;
	logic [11:0] raw_w;
	logic [11:0] avg_reg;
	logic [7:0] gain_reg;
	logic [7:0] gtrk_reg;
	logic push_reg;
	logic signed [12:0] dm_w;
	logic signed [8:0] dg_w;

	assign mag_w = cx_reg[12:1];
	assign raw_w = cz_reg[15:4];
	assign dm_w = $signed({1'b0, mag_w}) - $signed({1'b0, avg_reg});
	assign dg_w = $signed({1'b0, gain_reg}) - $signed({1'b0, gtrk_reg});

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			gain_reg <= AGC_RST;
		end else if (done_reg) begin
			if (mag_w > AGC_HI && gain_reg != 8'h00) begin // [RQ10]
				gain_reg <= gain_reg - 8'h01;
			end else if (mag_w < AGC_LO && gain_reg != 8'hFF) begin // [RQ10]
				gain_reg <= gain_reg + 8'h01;
			end
		end
	end

	// Trackers follow slowly, so drift never opens a large gap
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			avg_reg <= AGC_TGT;
			gtrk_reg <= AGC_RST;
			push_reg <= 1'b0;
		end else if (done_reg) begin
			avg_reg <= avg_reg + 12'(dm_w >>> TRACK_SH); // [RQ12]
			gtrk_reg <= gtrk_reg + 8'(dg_w >>> TRACK_SH); // [RQ12]
			push_reg <= dm_w > PUSH_THR || dm_w < -PUSH_THR || dg_w > GAIN_THR || dg_w < -GAIN_THR; // [RQ12]
		end
	end

	assign agc_gain_out = gain_reg;
	assign push_out = push_reg;

	agc_down_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [RQ10]
		done_reg && mag_w > AGC_HI && gain_reg != 8'h00 |=> gain_reg == $past(gain_reg) - 8'h01)
		else $error("gain not lowered on strong field");

	push_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [RQ12]
		done_reg && (dm_w > PUSH_THR || dm_w < -PUSH_THR) |=> push_out)
		else $error("push not raised on fast magnitude change");

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			snap_tgl_reg <= 1'b0;
			c_raw_reg <= 12'h000;
			c_ang_reg <= 12'h000;
			c_mag_reg <= 12'h000;
			c_agc_reg <= 8'h00;
		end else if (done_reg && snap_tgl_reg == ack_s2_reg) begin
			c_raw_reg <= raw_w;
			c_ang_reg <= raw_w - zero_c_reg;
			c_mag_reg <= mag_w;
			c_agc_reg <= gain_reg;
			snap_tgl_reg <= !snap_tgl_reg;
		end
	end

	// ------------------------------------------------------------
	// Quadrature generation
	// ------------------------------------------------------------
	logic [11:0] ang_reg;
	logic [11:0] pos_reg;
	logic [3:0] qs_w;
	logic [11:0] step_w;
	logic [11:0] posm_w;
	logic [11:0] diff_w;
	logic [1:0] ph_w;

	always_comb begin
		qs_w = (conf_c_reg[3:0] > 4'h8) ? 4'h9 : conf_c_reg[3:0] + 4'h1;
		step_w = 12'h001 << qs_w;
		posm_w = pos_reg & ~(step_w - 12'h001);
		diff_w = (ang_reg & ~(step_w - 12'h001)) - posm_w;
		ph_w = 2'(posm_w >> qs_w);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ang_reg <= 12'h000;
			pos_reg <= 12'h000;
			quad_a_out <= 1'b0;
			quad_b_out <= 1'b0;
		end else begin
			if (done_reg) begin
				ang_reg <= raw_w - zero_c_reg; // [RQ11]
			end
			// One step per core cycle along the shorter way round
			if (diff_w != 12'h000) begin // [RQ13] [RQ14]
				pos_reg <= diff_w[11] ? posm_w - step_w : posm_w + step_w;
			end else begin
				pos_reg <= posm_w;
			end
			quad_a_out <= ph_w[1]; // [RQ11] [RQ20]
			quad_b_out <= ph_w[1] ^ ph_w[0]; // [RQ20]
		end
	end

	quad_step_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [RQ20]
		$stable(qs_w) |-> 2'(ph_w - $past(ph_w)) inside {2'd0, 2'd1, 2'd3})
		else $error("quadrature phase skipped a quarter");

endmodule : eit_target_port

// [rtl/eit_pkg.sv]
// Purpose: Constants, types and helpers of the encoder two-wire target port
// Assumes: Core clock 10 MHz; link sample clock as given by LINK_CLK_KHZ
// Notes: Register offsets are the port's own map
package eit_pkg;

	// ------------------------------------------------------------
	// Bus addressing and timing
	// ------------------------------------------------------------
	localparam logic [6:0] TARGET_ADDR = 7'h36;
	localparam int CORE_CLK_KHZ = 10_000;
	localparam int LINK_CLK_KHZ = 166_667;
	localparam int SCL_MAX_KHZ = 1_000;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS * LINK_CLK_KHZ + 999_999) / 1_000_000;
	localparam int CNT_W = $clog2(SPIKE_CYC + 1);
	localparam int ITER = 12;

	// ------------------------------------------------------------
	// Register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REG_ZERO_HI = 8'h01;
	localparam logic [7:0] REG_ZERO_LO = 8'h02;
	localparam logic [7:0] REG_CONF = 8'h03;
	localparam logic [7:0] REG_STAT = 8'h0B;
	localparam logic [7:0] REG_RAW_HI = 8'h0C;
	localparam logic [7:0] REG_RAW_LO = 8'h0D;
	localparam logic [7:0] REG_ANG_HI = 8'h0E;
	localparam logic [7:0] REG_ANG_LO = 8'h0F;
	localparam logic [7:0] REG_AGC = 8'h1A;
	localparam logic [7:0] REG_MAG_HI = 8'h1B;
	localparam logic [7:0] REG_MAG_LO = 8'h1C;
	localparam logic [7:0] REG_BURN = 8'hFF;
	localparam logic [7:0] BURN_CMD = 8'h80;
	localparam logic [11:0] ZERO_RST = 12'h000;
	localparam logic [7:0] CONF_RST = 8'h00;

	// ------------------------------------------------------------
	// Gain control and push detection
	// ------------------------------------------------------------
	localparam logic [7:0] AGC_RST = 8'h80;
	localparam logic [11:0] AGC_TGT = 12'h0400;
	localparam logic [11:0] AGC_HI = 12'h0440;
	localparam logic [11:0] AGC_LO = 12'h03C0;
	localparam int TRACK_SH = 4;
	localparam logic signed [12:0] PUSH_THR = 13'sh0080;
	localparam logic signed [8:0] GAIN_THR = 9'sh008;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_MACK = 3'b100
	} eit_state_t;

	typedef enum logic [1:0] {
		BY_ADDR = 2'b00,
		BY_PTR = 2'b01,
		BY_DATA = 2'b10
	} eit_byte_t;

	// Arctangent of 2^-i, full turn = 2^16
	function automatic logic [15:0] eit_atan(input logic [3:0] i);
		case (i)
			4'h0: eit_atan = 16'h2000;
			4'h1: eit_atan = 16'h12E4;
			4'h2: eit_atan = 16'h09FB;
			4'h3: eit_atan = 16'h0511;
			4'h4: eit_atan = 16'h028B;
			4'h5: eit_atan = 16'h0146;
			4'h6: eit_atan = 16'h00A3;
			4'h7: eit_atan = 16'h0051;
			4'h8: eit_atan = 16'h0029;
			4'h9: eit_atan = 16'h0014;
			4'hA: eit_atan = 16'h000A;
			4'hB: eit_atan = 16'h0005;
			default: eit_atan = 16'h0000;
		endcase
	endfunction : eit_atan

	function automatic logic eit_reg_ok(input logic [7:0] a);
		case (a)
			REG_ZERO_HI, REG_ZERO_LO, REG_CONF, REG_STAT, REG_RAW_HI, REG_RAW_LO,
			REG_ANG_HI, REG_ANG_LO, REG_AGC, REG_MAG_HI, REG_MAG_LO, REG_BURN: eit_reg_ok = 1'b1;
			default: eit_reg_ok = 1'b0;
		endcase
	endfunction : eit_reg_ok

endpackage : eit_pkg

// [bench/eit_bus_ctl.sv]
// Purpose: Behavioural two-wire bus controller for the target port
// Assumes: Pull-up on the data line; the clock is driven only here
// Notes: Each write acknowledge bit and read byte is reported on res_stb_out
`timescale 1ns/10ps
module eit_bus_ctl (
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in,
	output logic res_stb_out,
	output logic [7:0] res_val_out
);
	localparam int HALF = 500;
	logic glitch = 1'b0;
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		res_stb_out = 1'b0;
		res_val_out = 8'h00;
	end
	task automatic report(input logic [7:0] v);
		res_val_out = v;
		res_stb_out = 1'b1;
		#10 res_stb_out = 1'b0;
	endtask : report
	// Clock stands high between frames
	task automatic start();
		#100 sda_low_out = 1'b0;
		#HALF scl_out = 1'b1;
		#HALF sda_low_out = 1'b1;
		#HALF scl_out = 1'b0;
	endtask : start
	task automatic stop();
		#100 sda_low_out = 1'b1;
		#HALF scl_out = 1'b1;
		#HALF sda_low_out = 1'b0;
		#HALF;
	endtask : stop
	// Data held 100 ns past the fall; optional 30 ns spikes on both lines
	task automatic bit_clk(input logic b, output logic s);
		#100 sda_low_out = !b;
		#100 scl_out = glitch;
		#30 scl_out = 1'b0;
		#270 scl_out = 1'b1;
		#100 sda_low_out = !b ^ glitch;
		#30 sda_low_out = !b;
		#120 s = sda_in;
		#250 scl_out = 1'b0;
	endtask : bit_clk
	task automatic wr(input logic [7:0] d);
		logic [7:0] r;
		logic a;
		for (int i = 7; i >= 0; i--) bit_clk(d[i], r[i]);
		bit_clk(1'b1, a);
		report({7'h00, a});
	endtask : wr
	task automatic rd(input logic last);
		logic [7:0] r;
		logic a;
		for (int i = 7; i >= 0; i--) bit_clk(1'b1, r[i]);
		bit_clk(last, a);
		report(r);
	endtask : rd
endmodule : eit_bus_ctl

// [bench/eit_target_port_bench.sv]
// Purpose: Self-checking bench of the encoder two-wire target port
// Assumes: Controller model on the bus, pull-up on the data line
// Notes: Bus results are compared in order against a queue of expected bytes
`timescale 1ns/10ps
module eit_target_port_bench
	import eit_pkg::*;
;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] sx = 12'h000;
	logic [11:0] sy = 12'h000;
	logic sv = 1'b0;
	logic scl, sda_low, res_stb, sda_out, sda_oe, qa, qb, push, burned;
	logic [7:0] res_val, gain, hi, lo;
	wire sda;
	int errors = 0;
	int comparisons = 0;
	logic [7:0] exp_q[$];
	assign sda = !sda_low && (sda_oe ? sda_out : 1'b1);
	initial forever #50 core_clk = !core_clk;
	initial begin
		#1.3;
		forever #3 link_clk = !link_clk;
	end
	eit_bus_ctl ctl_u (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda), .res_stb_out(res_stb),
		.res_val_out(res_val));
	eit_target_port dut_u (.core_clk_in(core_clk), .rst_n_in(rst_n), .link_clk_in(link_clk), .scl_in(scl),
		.sda_in(sda), .sda_out_out(sda_out), .sda_oe_out(sda_oe), .sample_x_in(sx), .sample_y_in(sy),
		.sample_valid_in(sv), .quad_a_out(qa), .quad_b_out(qb), .push_out(push), .agc_gain_out(gain),
		.otp_burned_out(burned));
	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", what, e, g);
			errors++;
		end
	endtask : chk
	always @(posedge res_stb) chk("bus byte", (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx, res_val);
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [7:0] d, input logic nack);
		exp_q.push_back({7'h00, nack});
		ctl_u.wr(d);
	endtask : wr
	task automatic rd(input logic [7:0] e, input logic last);
		exp_q.push_back(e);
		ctl_u.rd(last);
	endtask : rd
	task automatic sample(input logic [11:0] x, input logic [7:0] e, input logic p);
		@(negedge core_clk);
		sx = x;
		sy = 12'($urandom & 32'h003F);
		sv = 1'b1;
		@(negedge core_clk);
		sv = 1'b0;
		repeat (15) @(negedge core_clk);
		chk("gain", e, gain);
		chk("push", {7'h00, p}, {7'h00, push});
	endtask : sample
	initial begin
		void'($urandom(87714));
		hi = 8'($urandom) & 8'h0F;
		lo = 8'($urandom);
		repeat (8) @(negedge core_clk);
		chk("reset gain", AGC_RST, gain);
		chk("reset outs", 8'h00, {3'b000, sda_oe, qa, qb, push, burned});
		rst_n = 1'b1;
		#1000;
		ctl_u.start();
		wr(8'h6A, 1'b1);
		ctl_u.stop();
		$display("address test done");
		ctl_u.start();
		wr({TARGET_ADDR, 1'b0}, 1'b0);
		wr(REG_ZERO_HI, 1'b0);
		ctl_u.glitch = 1'b1;
		wr(hi, 1'b0);
		ctl_u.glitch = 1'b0;
		wr(lo, 1'b0);
		ctl_u.stop();
		$display("page write test done");
		ctl_u.start();
		wr({TARGET_ADDR, 1'b0}, 1'b0);
		wr(8'h00, 1'b1);
		ctl_u.start();
		wr({TARGET_ADDR, 1'b1}, 1'b0);
		rd(8'h00, 1'b0);
		rd(hi, 1'b0);
		rd(lo, 1'b1);
		ctl_u.stop();
		chk("data released", 8'h00, {7'h00, sda_oe});
		$display("read test done");
		ctl_u.start();
		wr({TARGET_ADDR, 1'b0}, 1'b0);
		wr(REG_BURN, 1'b0);
		wr(BURN_CMD, 1'b0);
		wr(~lo, 1'b1);
		ctl_u.start();
		wr({TARGET_ADDR, 1'b0}, 1'b0);
		wr(REG_ZERO_LO, 1'b0);
		wr(~lo, 1'b0);
		ctl_u.start();
		wr({TARGET_ADDR, 1'b0}, 1'b0);
		wr(REG_ZERO_LO, 1'b0);
		ctl_u.start();
		wr({TARGET_ADDR, 1'b1}, 1'b0);
		rd(lo, 1'b1);
		ctl_u.stop();
		chk("burned", 8'h01, {7'h00, burned});
		$display("burn test done");
		sample(12'h600 | 12'($urandom & 32'h00FF), AGC_RST - 8'h01, 1'b1);
		sample(12'h100 | 12'($urandom & 32'h003F), AGC_RST, 1'b1);
		$display("gain test done");
		chk("queue left", 8'h00, 8'(exp_q.size()));
		end_of_test();
	end
	initial begin
		#2_000_000;
		errors++;
		end_of_test();
	end
endmodule : eit_target_port_bench
